/* src/ait_defines.svh */
`ifndef AIT_DEFINES_SVH
`define AIT_DEFINES_SVH

// operation field, opcode bits [7:4]
`define AIT_OP_ADD   4'h0
`define AIT_OP_ADD_CARRY  4'h1
`define AIT_OP_SUB_BORROW 4'h2
`define AIT_OP_INC   4'h3
`define AIT_OP_DECREMENT  4'h4
`define AIT_OP_AND   4'h5
`define AIT_OP_OR    4'h6
`define AIT_OP_XOR   4'h7
`define AIT_OP_CLR   4'h8
`define AIT_OP_CPL   4'h9
`define AIT_OP_RL    4'ha
`define AIT_OP_RL_CARRY 4'hb
`define AIT_OP_RR    4'hc
`define AIT_OP_RR_CARRY 4'hd
`define AIT_OP_MISC  4'he

// operand mode field, opcode bits [3:0]; 4'h0..4'h7 register, 4'h8/4'h9 indirect
`define AIT_MD_IND   3'h4
`define AIT_MD_DIR   4'ha
`define AIT_MD_IMM   4'hb
`define AIT_MD_ACC   4'hc
`define AIT_MD_DACC  4'hd
`define AIT_MD_DIMM  4'he

// sub-operations of the misc group, in the mode field
`define AIT_MI_INCDP 4'h0
`define AIT_MI_MUL   4'h1
`define AIT_MI_DIV   4'h2
`define AIT_MI_BCD_ADJ 4'h3

// encoded lengths in bytes and execution times in cycles
`define AIT_LEN_1    2'h1
`define AIT_LEN_2    2'h2
`define AIT_LEN_3    2'h3
`define AIT_CYC_1    4'h1
`define AIT_CYC_2    4'h2
`define AIT_CYC_3    4'h3
`define AIT_CYC_DIV  4'ha

// reset values and decimal adjust constants
`define AIT_RST_BYTE 8'h00
`define AIT_RST_WORD 16'h0000
`define AIT_BCD_MAX  4'h9
`define AIT_DA_LO    9'h006
`define AIT_DA_HI    9'h060

`endif

/* src/ait_pkg.sv */
`default_nettype none
package ait_pkg;

  typedef enum logic [1:0] {ST_FETCH, ST_OPER1, ST_OPER2, ST_EXEC} ait_state_e;

  typedef struct packed {
    logic cy;
    logic ac;
    logic ov;
  } ait_flags_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ait_byte_s;

  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } ait_memwr_s;

endpackage : ait_pkg
`default_nettype wire

/* src/ait_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ait_defines.svh"

// Overview of operation
// RQ1 - add direct byte: two bytes, one cycle; register and indirect: one byte, one cycle
// RQ2 - add with carry from register, direct, indirect, immediate; one cycle each
// RQ3 - subtract with borrow from register, direct, indirect, immediate in one cycle
// RQ4 - subtract with borrow immediate: two bytes, one cycle
// RQ5 - and direct byte into accumulator: two bytes, two cycles; other sources one cycle
// RQ6 - and immediate into accumulator: two bytes, one cycle
// RQ7 - and accumulator into direct byte: two bytes, two cycles
// RQ8 - and immediate into direct byte: three bytes, two cycles
// RQ9 - or direct byte into accumulator: two bytes, two cycles; register one byte, one cycle
// RQ10 - or immediate into direct: three bytes, two cycles; accumulator into direct: two, two
// RQ11 - xor direct into accumulator two cycles; indirect and immediate one cycle
// RQ12 - xor immediate into direct byte: three bytes, two cycles
// RQ13 - rotate left through carry: one byte, one cycle, carry in and out
// RQ14 - rotate right through carry, rotates, clear, complement: one byte, one cycle
// RQ15 - increment/decrement accumulator, register, indirect one cycle; direct two bytes, two cycles
// RQ16 - data pointer increment and multiply three cycles, divide ten; all one byte
// RQ17 - decimal adjust of accumulator: one byte, one cycle
module ait_core (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire ait_pkg::ait_byte_s  code_in,
  output var  logic                code_ready,
  input  wire ait_pkg::ait_memwr_s preload,
  output var  logic [7:0]          acc_out,
  output var  logic [7:0]          b_out,
  output var  ait_pkg::ait_flags_s flags_out,
  output var  logic [15:0]         data_pointer_out,
  output var  ait_pkg::ait_memwr_s mem_wr_out,
  output var  logic                done,
  output var  logic                illegal,
  output var  logic                busy
);
  import ait_pkg::*;

  ait_state_e  state_reg, state_next;
  logic [7:0]  op_reg, op1_reg, op2_reg;
  logic [3:0]  cnt_reg, cnt_next;
  logic [7:0]  acc_reg, b_reg;
  logic [15:0] data_pointer_reg;
  ait_flags_s  flags_reg;
  logic [7:0]  ram [0:127];

  // decode of the opcode being fetched or executed
  wire        take     = code_in.valid & code_ready;
  wire [7:0]  cur_op   = (state_reg == ST_FETCH) ? code_in.data : op_reg;
  wire [3:0]  c_op     = cur_op[7:4];
  wire [3:0]  c_md     = cur_op[3:0];
  wire        c_arith  = (c_op == `AIT_OP_ADD) | (c_op == `AIT_OP_ADD_CARRY) | (c_op == `AIT_OP_SUB_BORROW);
  wire        c_incdec = (c_op == `AIT_OP_INC) | (c_op == `AIT_OP_DECREMENT);
  wire        c_logic  = (c_op == `AIT_OP_AND) | (c_op == `AIT_OP_OR) | (c_op == `AIT_OP_XOR);
  wire        c_accop  = (c_op >= `AIT_OP_CLR) & (c_op <= `AIT_OP_RR_CARRY);
  wire        c_misc   = (c_op == `AIT_OP_MISC);
  wire        c_legal  = (c_arith & (c_md < `AIT_MD_ACC))
                       | (c_incdec & ((c_md < `AIT_MD_IMM) | (c_md == `AIT_MD_ACC)))
                       | (c_logic & ((c_md < `AIT_MD_ACC) | (c_md == `AIT_MD_DACC) | (c_md == `AIT_MD_DIMM)))
                       | (c_accop & (c_md == `AIT_MD_ACC))
                       | (c_misc & (c_md <= `AIT_MI_BCD_ADJ));

  // lengths follow the operand mode alone
  wire [1:0]  c_len = (c_md == `AIT_MD_DIMM) ? `AIT_LEN_3 :                          // RQ8 RQ10 RQ12
                      ((c_md == `AIT_MD_DIR) | (c_md == `AIT_MD_IMM) | (c_md == `AIT_MD_DACC)) ? `AIT_LEN_2 :
                      `AIT_LEN_1;                                                      // RQ1 RQ4 RQ6 RQ7

  wire        c_logic_slow = c_logic & ((c_md == `AIT_MD_DIR) | (c_md == `AIT_MD_DACC)
                                      | (c_md == `AIT_MD_DIMM));                       // RQ5 RQ7 RQ9 RQ11
  wire [3:0]  c_cyc = (c_misc & (c_md == `AIT_MI_DIV)) ? `AIT_CYC_DIV :               // RQ16
                      (c_misc & (c_md != `AIT_MI_BCD_ADJ)) ? `AIT_CYC_3 :              // RQ16
                      c_logic_slow ? `AIT_CYC_2 :
                      (c_incdec & (c_md == `AIT_MD_DIR)) ? `AIT_CYC_2 :               // RQ15
                      `AIT_CYC_1;                                                      // RQ2 RQ3 RQ13 RQ14 RQ17

  wire [3:0]  c_cyc_m1 = c_cyc - `AIT_CYC_1;

  // operand selection, valid during execution only
  wire [3:0]  x_op     = op_reg[7:4];
  wire [3:0]  x_md     = op_reg[3:0];
  wire        x_reg    = ~x_md[3];
  wire        x_ind    = (x_md[3:1] == `AIT_MD_IND);
  wire [6:0]  ptr_addr = {6'h00, x_md[0]};
  wire [6:0]  mem_addr = x_reg ? {4'h0, x_md[2:0]} : x_ind ? ram[ptr_addr][6:0] : op1_reg[6:0];
  wire [7:0]  mem_val  = ram[mem_addr];
  wire        to_mem   = (x_md == `AIT_MD_DACC) | (x_md == `AIT_MD_DIMM)
                       | (((x_op == `AIT_OP_INC) | (x_op == `AIT_OP_DECREMENT)) & (x_md != `AIT_MD_ACC));
  wire [7:0]  src      = (x_md == `AIT_MD_IMM)  ? op1_reg :
                         (x_md == `AIT_MD_DACC) ? acc_reg :
                         (x_md == `AIT_MD_DIMM) ? op2_reg : mem_val;
  wire [7:0]  opx      = to_mem ? mem_val : acc_reg;
  wire        commit   = (state_reg == ST_EXEC) & (cnt_reg == 4'h0);

  // arithmetic
  wire        cin      = (x_op == `AIT_OP_ADD) ? 1'b0 : flags_reg.cy;
  wire [8:0]  sum      = {1'b0, opx} + {1'b0, src} + {8'h00, cin};
  wire [4:0]  sum_lo   = {1'b0, opx[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
  wire [8:0]  dif      = {1'b0, opx} - {1'b0, src} - {8'h00, flags_reg.cy};
  wire [4:0]  dif_lo   = {1'b0, opx[3:0]} - {1'b0, src[3:0]} - {4'h0, flags_reg.cy};
  wire [15:0] prod     = {8'h00, acc_reg} * {8'h00, b_reg};
  wire        div_zero = (b_reg == `AIT_RST_BYTE);
  wire [7:0]  quot     = div_zero ? acc_reg : acc_reg / b_reg;
  wire [7:0]  rem      = div_zero ? b_reg : acc_reg % b_reg;
  wire        da_lo_f  = (acc_reg[3:0] > `AIT_BCD_MAX) | flags_reg.ac;
  wire [8:0]  da_s1    = {1'b0, acc_reg} + (da_lo_f ? `AIT_DA_LO : 9'h000);
  wire        da_c1    = flags_reg.cy | da_s1[8];
  wire        da_hi_f  = (da_s1[7:4] > `AIT_BCD_MAX) | da_c1;
  wire [8:0]  da_s2    = {1'b0, da_s1[7:0]} + (da_hi_f ? `AIT_DA_HI : 9'h000);

  logic [7:0] res;
  ait_flags_s flg;
  // b has no load path in this block; only multiply and divide move it
  logic [7:0] b_new;
  logic       b_we;

  always_comb begin
    res   = opx;
    flg   = flags_reg;
    b_new = b_reg;
    b_we  = 1'b0;
    unique case (x_op)
      `AIT_OP_ADD, `AIT_OP_ADD_CARRY: begin                                             // RQ1 RQ2
        res    = sum[7:0];
        flg.cy = sum[8];
        flg.ac = sum_lo[4];
        flg.ov = (opx[7] == src[7]) & (sum[7] != opx[7]);
      end
      `AIT_OP_SUB_BORROW: begin                                                         // RQ3 RQ4
        res    = dif[7:0];
        flg.cy = dif[8];
        flg.ac = dif_lo[4];
        flg.ov = (opx[7] != src[7]) & (dif[7] != opx[7]);
      end
      `AIT_OP_INC:  res = opx + 8'h01;                                                  // RQ15
      `AIT_OP_DECREMENT: res = opx - 8'h01;                                             // RQ15
      `AIT_OP_AND:  res = opx & src;                                                    // RQ5 RQ6 RQ7 RQ8
      `AIT_OP_OR:   res = opx | src;                                                    // RQ9 RQ10
      `AIT_OP_XOR:  res = opx ^ src;                                                    // RQ11 RQ12
      `AIT_OP_CLR:  res = `AIT_RST_BYTE;                                                // RQ14
      `AIT_OP_CPL:  res = ~acc_reg;                                                     // RQ14
      `AIT_OP_RL:   res = {acc_reg[6:0], acc_reg[7]};                                   // RQ14
      `AIT_OP_RL_CARRY: begin                                                           // RQ13
        res    = {acc_reg[6:0], flags_reg.cy};
        flg.cy = acc_reg[7];
      end
      `AIT_OP_RR:   res = {acc_reg[0], acc_reg[7:1]};                                   // RQ14
      `AIT_OP_RR_CARRY: begin                                                           // RQ14
        res    = {flags_reg.cy, acc_reg[7:1]};
        flg.cy = acc_reg[0];
      end
      `AIT_OP_MISC: begin
        unique case (x_md)
          `AIT_MI_MUL: begin                                                            // RQ16
            res    = prod[7:0];
            b_new  = prod[15:8];
            b_we   = 1'b1;
            flg.cy = 1'b0;
            flg.ov = (prod[15:8] != `AIT_RST_BYTE);
          end
          `AIT_MI_DIV: begin                                                            // RQ16
            // divide by zero leaves both operands as they were and flags overflow
            res    = quot;
            b_new  = rem;
            b_we   = 1'b1;
            flg.cy = 1'b0;
            flg.ov = div_zero;
          end
          `AIT_MI_BCD_ADJ: begin                                                        // RQ17
            res    = da_s2[7:0];
            flg.cy = da_c1 | da_s2[8];
          end
          default: res = acc_reg;
        endcase
      end
      default: res = acc_reg;
    endcase
  end

  wire mem_we          = commit & to_mem;
  wire acc_we          = commit & ~to_mem & ~((x_op == `AIT_OP_MISC) & (x_md == `AIT_MI_INCDP));
  wire data_pointer_we = commit & (x_op == `AIT_OP_MISC) & (x_md == `AIT_MI_INCDP);      // RQ16

  // sequencing: fetch opcode, then operand bytes, then hold for the cycle count
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      ST_FETCH: if (take & c_legal) begin
        if (c_len == `AIT_LEN_1) begin
          state_next = ST_EXEC;
          cnt_next   = c_cyc_m1;
        end else begin
          state_next = ST_OPER1;
        end
      end
      ST_OPER1: if (take) begin
        if (c_len == `AIT_LEN_3) begin
          state_next = ST_OPER2;
        end else begin
          state_next = ST_EXEC;
          cnt_next   = c_cyc_m1;
        end
      end
      ST_OPER2: if (take) begin
        state_next = ST_EXEC;
        cnt_next   = c_cyc_m1;
      end
      ST_EXEC: begin
        if (commit) begin
          state_next = ST_FETCH;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_FETCH;
      cnt_reg   <= 4'h0;
      op_reg    <= `AIT_RST_BYTE;
      op1_reg   <= `AIT_RST_BYTE;
      op2_reg   <= `AIT_RST_BYTE;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      if (take & (state_reg == ST_FETCH)) op_reg <= code_in.data;
      if (take & (state_reg == ST_OPER1)) op1_reg <= code_in.data;
      if (take & (state_reg == ST_OPER2)) op2_reg <= code_in.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_reg          <= `AIT_RST_BYTE;
      b_reg            <= `AIT_RST_BYTE;
      data_pointer_reg <= `AIT_RST_WORD;
      flags_reg        <= '0;
    end else begin
      if (acc_we) acc_reg <= res;
      if (commit & b_we) b_reg <= b_new;
      if (data_pointer_we) data_pointer_reg <= data_pointer_reg + 16'h0001;
      if (commit) flags_reg <= flg;
    end
  end

  // result write wins over a preload aimed at the same cycle
  always_ff @(posedge clk) begin
    if (mem_we) begin
      ram[mem_addr] <= res;
    end else if (preload.en) begin
      ram[preload.addr] <= preload.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      code_ready <= 1'b0;
      busy       <= 1'b0;
      done       <= 1'b0;
      illegal    <= 1'b0;
      mem_wr_out <= '0;
    end else begin
      code_ready <= (state_next != ST_EXEC);
      busy       <= (state_next != ST_FETCH);
      done       <= commit;
      illegal    <= take & (state_reg == ST_FETCH) & ~c_legal;
      mem_wr_out <= '{en: mem_we, addr: mem_addr, data: res};
    end
  end

  assign acc_out          = acc_reg;
  assign b_out            = b_reg;
  assign flags_out        = flags_reg;
  assign data_pointer_out = data_pointer_reg;

endmodule : ait_core

`default_nettype wire

/* tb/ait_core_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ait_core_checker (
  input wire logic                clk,
  input wire logic                rst,
  input wire ait_pkg::ait_byte_s  code_in,
  input wire logic                code_ready,
  input wire logic [7:0]          acc_out,
  input wire ait_pkg::ait_flags_s flags_out,
  input wire logic                done,
  input wire logic                busy
);
  import ait_pkg::*;
  logic [1:0] pos_reg;
  logic [7:0] op_reg;
  logic [7:0] a_reg;
  logic       cy_reg;
  wire        take  = code_in.valid & code_ready;
  wire        first = take & (pos_reg == 2'h0);
  wire [7:0]  op    = first ? code_in.data : op_reg;
  wire [3:0]  md    = op[3:0];
  wire [1:0]  len   = (op[7:4] > 4'h7 || md < 4'ha || md == 4'hc) ? 2'h1 : (md == 4'he ? 2'h3 : 2'h2);
  // direct forms of the logic and inc/dec groups are the slow ones
  wire [3:0]  cyc   = op[7:4] == 4'he ? (op[1] ? (op[0] ? 4'h1 : 4'ha) : 4'h3) :
                      (op[7:4] > 4'h2 && op[7:4] < 4'h8 && (md == 4'ha || md > 4'hc)) ? 4'h2 : 4'h1;
  wire        fin   = take & (pos_reg + 2'h1 == len);
  wire        last  = fin & (op[7:4] != 4'hf);
  always_ff @(posedge clk) begin
    if (rst || fin) pos_reg <= 2'h0;
    else if (take) pos_reg <= pos_reg + 2'h1;
  end
  always_ff @(posedge clk) begin
    if (first) begin
      op_reg <= code_in.data;
      a_reg  <= acc_out;
      cy_reg <= flags_out.cy;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_one_cycle: assert property (
    last && cyc == 4'h1 |-> ##1 !done ##1 done) else $error("one-cycle op mistimed");
  chk_two_cycle: assert property (
    last && cyc == 4'h2 |-> ##1 !done [*2] ##1 done) else $error("two-cycle op mistimed");
  chk_three_cycle: assert property (
    last && cyc == 4'h3 |-> ##1 !done [*3] ##1 done) else $error("three-cycle op mistimed");
  chk_divide_wait: assert property (
    last && cyc == 4'ha |-> ##1 (busy && !done) [*8] ##1 !done ##1 !done ##1 done)
    else $error("divide mistimed");
  chk_ready_drops: assert property (
    last |=> !code_ready && busy) else $error("byte taken past instruction end");
  chk_more_bytes: assert property (
    take && !fin |=> code_ready && !done) else $error("operand byte refused");
  chk_rotate_left: assert property (
    first && code_in.data == 8'hbc |-> ##2 acc_out == {a_reg[6:0], cy_reg} && flags_out.cy == a_reg[7])
    else $error("left rotate through carry wrong");
  chk_rotate_right: assert property (
    first && code_in.data == 8'hdc |-> ##2 acc_out == {cy_reg, a_reg[7:1]} && flags_out.cy == a_reg[0])
    else $error("right rotate through carry wrong");
  chk_clear_acc: assert property (
    first && code_in.data == 8'h8c |-> ##2 acc_out == 8'h00) else $error("clear failed");
endmodule : ait_core_checker
bind ait_core ait_core_checker i_ait_core_checker (.clk, .rst, .code_in, .code_ready, .acc_out, .flags_out,
  .done, .busy);
`default_nettype wire

/* tb/ait_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module ait_prog_mem (
  input  wire logic               clk,
  input  wire logic               code_ready,
  output var  ait_pkg::ait_byte_s code_in
);
  import ait_pkg::*;
  logic [7:0] q[$];
  logic       took  = 1'b0;
  logic       slow  = 1'b0;
  ait_byte_s  offer = 9'h000;
  assign code_in = offer;
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask : push
  always @(posedge clk) took = code_in.valid & code_ready;
  // held until taken; idle data toggles so a stale byte never looks valid
  always @(negedge clk) begin
    if (took) void'(q.pop_front());
    if (q.size() != 0 && !(slow && took)) offer <= {1'b1, q[0]};
    else offer <= {1'b0, ~offer.data};
  end
endmodule : ait_prog_mem
`default_nettype wire

/* tb/mcu_alu_instruction_timing_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module mcu_alu_instruction_timing_tb;
  import ait_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  ait_memwr_s  preload = 16'h0000;
  ait_byte_s   code_in;
  logic        code_ready, done, illegal, busy;
  logic [7:0]  acc_out, b_out;
  ait_flags_s  flags_out;
  logic [15:0] data_pointer_out;
  ait_memwr_s  mem_wr_out;
  int          fail_count = 0;
  int          num_checks = 0;
  always #5 clk = ~clk;
  ait_core i_ait_core (.clk, .rst, .code_in, .code_ready, .preload, .acc_out, .b_out, .flags_out,
    .data_pointer_out, .mem_wr_out, .done, .illegal, .busy);
  ait_prog_mem i_ait_prog_mem (.clk, .code_ready, .code_in);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic poke(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    preload <= {1'b1, a, d};
    @(negedge clk);
    preload <= 16'h0000;
  endtask : poke
  // one instruction; returns in the cycle its done or illegal pulse stands
  task automatic run(input logic [7:0] b0, b1, b2, input int n, input logic ill);
    i_ait_prog_mem.push(b0);
    if (n > 1) i_ait_prog_mem.push(b1);
    if (n > 2) i_ait_prog_mem.push(b2);
    @(negedge clk);
    for (int i = 0; i < 40 && (done | illegal) !== 1'b1; i++) @(negedge clk);
    check({6'h00, done, illegal}, {6'h00, ~ill, ill});
  endtask : run
  task automatic t_arith;
    poke(7'h03, 8'h25);
    poke(7'h00, 8'h03);
    run(8'h8c, 8'h00, 8'h00, 1, 1'b0);
    run(8'h0b, 8'h7f, 8'h00, 2, 1'b0);
    run(8'h03, 8'h00, 8'h00, 1, 1'b0);
    check(acc_out, 8'ha4);
    check({5'h00, flags_out}, 8'h03);
    run(8'h0b, 8'h5c, 8'h00, 2, 1'b0);
    run(8'h1a, 8'h03, 8'h00, 2, 1'b0);
    check(acc_out, 8'h26);
    run(8'h2b, 8'h27, 8'h00, 2, 1'b0);
    check({acc_out[6:0], flags_out.cy}, 8'hff);
    run(8'h28, 8'h00, 8'h00, 1, 1'b0);
    check({acc_out[6:0], flags_out.cy}, 8'hb2);
  endtask : t_arith
  task automatic t_logic;
    i_ait_prog_mem.slow = 1'b1;
    poke(7'h10, 8'hf0);
    run(8'h5a, 8'h03, 8'h00, 2, 1'b0);
    check(acc_out, 8'h01);
    run(8'h5e, 8'h10, 8'h3c, 3, 1'b0);
    check({mem_wr_out.en, mem_wr_out.addr}, 8'h90);
    check(mem_wr_out.data, 8'h30);
    run(8'h6e, 8'h10, 8'h0f, 3, 1'b0);
    check(mem_wr_out.data, 8'h3f);
    run(8'h7a, 8'h10, 8'h00, 2, 1'b0);
    check(acc_out, 8'h3e);
    run(8'h7e, 8'h10, 8'hff, 3, 1'b0);
    check(mem_wr_out.data, 8'hc0);
    run(8'h5d, 8'h10, 8'h00, 2, 1'b0);
    check(mem_wr_out.data, 8'h00);
    run(8'h6a, 8'h10, 8'h00, 2, 1'b0);
    check(acc_out, 8'h3e);
    run(8'h6d, 8'h10, 8'h00, 2, 1'b0);
    check(mem_wr_out.data, 8'h3e);
    run(8'h5b, 8'hf0, 8'h00, 2, 1'b0);
    check(acc_out, 8'h30);
    i_ait_prog_mem.slow = 1'b0;
  endtask : t_logic
  task automatic t_rotate;
    logic [7:0] ops [5] = '{8'h9c, 8'hbc, 8'hdc, 8'hac, 8'hcc};
    logic [7:0] exp [5] = '{8'hcf, 8'h9e, 8'hcf, 8'h9f, 8'hcf};
    for (int i = 0; i < 5; i++) begin
      run(ops[i], 8'h00, 8'h00, 1, 1'b0);
      check(acc_out, exp[i]);
    end
  endtask : t_rotate
  task automatic t_incdec;
    run(8'h3c, 8'h00, 8'h00, 1, 1'b0);
    check(acc_out, 8'hd0);
    run(8'h43, 8'h00, 8'h00, 1, 1'b0);
    check(mem_wr_out.data, 8'h24);
    run(8'h3a, 8'h10, 8'h00, 2, 1'b0);
    check(mem_wr_out.data, 8'h3f);
    run(8'h48, 8'h00, 8'h00, 1, 1'b0);
    check(mem_wr_out.data, 8'h23);
  endtask : t_incdec
  task automatic t_misc;
    run(8'h8c, 8'h00, 8'h00, 1, 1'b0);
    run(8'h0b, 8'h38, 8'h00, 2, 1'b0);
    run(8'h0b, 8'h29, 8'h00, 2, 1'b0);
    run(8'he3, 8'h00, 8'h00, 1, 1'b0);
    check(acc_out, 8'h67);
    run(8'he1, 8'h00, 8'h00, 1, 1'b0);
    check(acc_out, 8'h00);
    check(b_out, 8'h00);
    run(8'he2, 8'h00, 8'h00, 1, 1'b0);
    check({6'h00, flags_out.cy, flags_out.ov}, 8'h01);
    check(b_out, 8'h00);
    run(8'he0, 8'h00, 8'h00, 1, 1'b0);
    run(8'he0, 8'h00, 8'h00, 1, 1'b0);
    check(data_pointer_out[7:0], 8'h02);
    run(8'hf0, 8'h00, 8'h00, 1, 1'b1);
    check(acc_out, 8'h00);
  endtask : t_misc
  // reset lands while a divide is still counting
  task automatic t_reset;
    i_ait_prog_mem.push(8'he2);
    repeat (4) @(negedge clk);
    rst <= 1'b1;
    @(negedge clk);
    rst <= 1'b0;
    check({6'h00, busy, done}, 8'h00);
    repeat (2) @(negedge clk);
  endtask : t_reset
  initial begin
    repeat (8) @(negedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    t_arith();
    t_logic();
    t_rotate();
    t_incdec();
    t_misc();
    t_reset();
    end_sim();
  end
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
endmodule : mcu_alu_instruction_timing_tb
`default_nettype wire
